//--- logic/ocfg_ch5_config.sv
// channel five output configuration registers behind an ahb-lite slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - source field: 00/11 pll, 01 primary input, 10 secondary input
// - prescale code 000 divides by 2, 001 by 3, 111 by 1
// - prescaler is bypassed whenever the fraction enable bit is zero
// - bit 9 disables (0) or enables (1) the fractional divider
// - bit 8 selects normal (0) or slow (1) lvcmos edge rate
// - bit 6 switches the positive lvcmos side on or off
// - bits 4:3 pick driver: 00/01 lvds, 10 lvcmos, 11 hcsl
// - bits 2:1: off, run clock, static low, static high
// - bit 0 gives supply level, 0 for 1.8 v, reset at 0
// - integer divide ratio is the 8-bit field plus one
// - 20-bit fraction: bits 19:16 in one register, 15:0 in next
// - channel four fraction low sixteen bits fill the preceding register
module ocfg_ch5_config (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ocfg_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// vco range strap
	input wire logic vco_above_2g4,
	// decoded channel five settings and the channel four fraction
	output ocfg_pkg::ocfg_source_e ch5_source_select,
	output logic [2:0] ch5_prescale_code,
	output logic [1:0] ch5_prescale_ratio,
	output logic ch5_prescale_bypass,
	output logic ch5_prescale_illegal,
	output logic ch5_fraction_enable,
	output logic ch5_edge_rate,
	output logic ch5_positive_side_on,
	output logic ch5_negative_side_on,
	output ocfg_pkg::ocfg_driver_e ch5_driver_type,
	output ocfg_pkg::ocfg_state_e ch5_output_state,
	output logic ch5_clock_run,
	output logic ch5_static_drive,
	output logic ch5_static_level,
	output logic ch5_supply_level,
	output logic [ocfg_pkg::INT_W:0] ch5_integer_divide,
	output logic [ocfg_pkg::FRAC_W-1:0] ch5_fraction_value,
	output logic [ocfg_pkg::REG_W-1:0] ch4_fraction_value
);
	import ocfg_pkg::*;

	logic dp_valid_reg;
	logic dp_write_reg;
	logic [5:0] dp_index_reg;
	logic [31:0] hrdata_reg;
	logic [15:0] c4f_reg;
	logic [15:0] ctl_reg;
	logic [15:0] dvh_reg;
	logic [15:0] c5f_reg;
	logic [15:0] c4f_next;
	logic [15:0] ctl_next;
	logic [15:0] dvh_next;
	logic [15:0] c5f_next;
	logic [15:0] hw16;
	logic [15:0] rd_value;
	logic addr_take;
	logic addr_mapped;
	logic [5:0] addr_index;
	logic wr_phase;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign hw16 = hwdata[REG_W-1:0];
	assign addr_take = hsel && hready && ((htrans & HTRANS_NONSEQ_BIT) != 2'h0);
	assign addr_index = haddr[IDX_HI:IDX_LO];
	// only whole aligned words inside the low window are decoded
	assign addr_mapped = (haddr[ADDR_W-1:IDX_HI+1] == '0) &&
		(haddr[IDX_LO-1:0] == 2'h0) && (hsize == 3'h2);
	assign wr_phase = dp_valid_reg && dp_write_reg;

	// address phase capture
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_index_reg <= 6'h00;
		end else if (hready) begin
			dp_valid_reg <= addr_take && addr_mapped;
			dp_write_reg <= hwrite;
			dp_index_reg <= addr_index;
		end
	end

	// write data lands in its data phase; reserved bits are masked off
	always_comb begin
		c4f_next = c4f_reg;
		ctl_next = ctl_reg;
		dvh_next = dvh_reg;
		c5f_next = c5f_reg;
		if (wr_phase) begin
			case (dp_index_reg)
				IDX_CH4_FRAC_LO: c4f_next = hw16 & MASK_CH4_FRAC_LO;
				IDX_CH5_CTRL: ctl_next = hw16 & MASK_CH5_CTRL;
				IDX_CH5_DIV_HI: dvh_next = hw16 & MASK_CH5_DIV_HI;
				IDX_CH5_FRAC_LO: c5f_next = hw16 & MASK_CH5_FRAC_LO;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			c4f_reg <= RST_CH4_FRAC_LO;
			ctl_reg <= RST_CH5_CTRL;
			dvh_reg <= RST_CH5_DIV_HI;
			c5f_reg <= RST_CH5_FRAC_LO;
		end else begin
			c4f_reg <= c4f_next;
			ctl_reg <= ctl_next;
			dvh_reg <= dvh_next;
			c5f_reg <= c5f_next;
		end
	end

	// read mux uses next values so a read right after a write sees it
	always_comb begin
		case (addr_index)
			IDX_CH4_FRAC_LO: rd_value = c4f_next;
			IDX_CH5_CTRL: rd_value = ctl_next;
			IDX_CH5_DIV_HI: rd_value = dvh_next;
			IDX_CH5_FRAC_LO: rd_value = c5f_next;
			default: rd_value = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_reg <= 32'h00000000;
		end else if (addr_take && !hwrite) begin
			hrdata_reg <= addr_mapped ? {16'h0000, rd_value} : 32'h00000000;
		end
	end

	// decode of the control word, from next values so outputs track writes
	ocfg_source_e src_next;
	logic [1:0] ratio_next;
	logic bypass_next;
	logic illegal_next;
	ocfg_driver_e drv_next;
	logic [2:0] pre_code;

	assign pre_code = ctl_next[PRE_HI:PRE_LO];

	always_comb begin
		case (ctl_next[SRC_HI:SRC_LO])
			2'b01: src_next = OCFG_SRC_PRIMARY;
			2'b10: src_next = OCFG_SRC_SECONDARY;
			default: src_next = OCFG_SRC_PLL;
		endcase
	end

	always_comb begin
		ratio_next = RATIO_1;
		bypass_next = 1'b1;
		illegal_next = 1'b0;
		if (ctl_next[FEN_BIT]) begin
			bypass_next = 1'b0;
			case (pre_code)
				PRE_DIV2: ratio_next = RATIO_2;
				PRE_DIV3: ratio_next = RATIO_3;
				PRE_DIV1: begin
					// divide by one is flagged when the vco runs too fast
					ratio_next = RATIO_1;
					illegal_next = vco_above_2g4;
				end
				default: begin
					ratio_next = RATIO_NONE;
					illegal_next = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		case (ctl_next[DRV_HI:DRV_LO])
			2'b10: drv_next = OCFG_DRV_LVCMOS;
			2'b11: drv_next = OCFG_DRV_HCSL;
			default: drv_next = OCFG_DRV_LVDS;
		endcase
	end

	// registered outputs
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch5_source_select <= OCFG_SRC_PLL;
			ch5_prescale_code <= PRE_DIV2;
			ch5_prescale_ratio <= RATIO_1;
			ch5_prescale_bypass <= 1'b1;
			ch5_prescale_illegal <= 1'b0;
			ch5_driver_type <= OCFG_DRV_LVDS;
		end else begin
			ch5_source_select <= src_next;
			ch5_prescale_code <= pre_code;
			ch5_prescale_ratio <= ratio_next;
			ch5_prescale_bypass <= bypass_next;
			ch5_prescale_illegal <= illegal_next;
			ch5_driver_type <= drv_next;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch5_fraction_enable <= 1'b0;
			ch5_edge_rate <= 1'b0;
			ch5_positive_side_on <= 1'b0;
			ch5_negative_side_on <= 1'b0;
			ch5_supply_level <= 1'b0;
		end else begin
			ch5_fraction_enable <= ctl_next[FEN_BIT];
			ch5_edge_rate <= ctl_next[SLEW_BIT];
			ch5_positive_side_on <= ctl_next[POS_BIT];
			// guard against a negative side left on alone
			ch5_negative_side_on <= ctl_next[NEG_BIT] && ctl_next[POS_BIT];
			ch5_supply_level <= ctl_next[SUP_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch5_output_state <= OCFG_ST_OFF;
			ch5_clock_run <= 1'b0;
			ch5_static_drive <= 1'b0;
			ch5_static_level <= 1'b0;
		end else begin
			case (ctl_next[ST_HI:ST_LO])
				2'b01: ch5_output_state <= OCFG_ST_RUN;
				2'b10: ch5_output_state <= OCFG_ST_LOW;
				2'b11: ch5_output_state <= OCFG_ST_HIGH;
				default: ch5_output_state <= OCFG_ST_OFF;
			endcase
			ch5_clock_run <= ctl_next[ST_HI:ST_LO] == 2'b01;
			ch5_static_drive <= ctl_next[ST_HI];
			ch5_static_level <= ctl_next[ST_HI:ST_LO] == 2'b11;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			// cleared field means divide by one, so reset shows that ratio
			ch5_integer_divide <= (INT_W+1)'(1);
			ch5_fraction_value <= '0;
			ch4_fraction_value <= '0;
		end else begin
			ch5_integer_divide <= {1'b0, dvh_next[DIV_HI:DIV_LO]} +
				(INT_W+1)'(1);
			ch5_fraction_value <= {dvh_next[FHI_HI:FHI_LO], c5f_next};
			ch4_fraction_value <= c4f_next;
		end
	end

	// checks
	sequence s_ctl_write;
		wr_phase && (dp_index_reg == IDX_CH5_CTRL);
	endsequence
	sequence s_frac_write;
		wr_phase && (dp_index_reg == IDX_CH5_FRAC_LO);
	endsequence
	sequence s_c4_write;
		wr_phase && (dp_index_reg == IDX_CH4_FRAC_LO);
	endsequence

	a_source_primary:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		s_ctl_write ##0 (hw16[SRC_HI:SRC_LO] == 2'b01)
		|=> ch5_source_select == OCFG_SRC_PRIMARY)
		else $error("source select not primary");
	a_prescale_div3:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		(ctl_reg[FEN_BIT] && ctl_reg[PRE_HI:PRE_LO] == PRE_DIV3)
		|-> ch5_prescale_ratio == RATIO_3)
		else $error("prescale code 001 not divide by 3");
	a_prescale_bypass:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		!ctl_reg[FEN_BIT] |-> ch5_prescale_bypass &&
		ch5_prescale_ratio == RATIO_1)
		else $error("prescaler not bypassed");
	a_fraction_enable:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		s_ctl_write |=> ch5_fraction_enable == $past(hw16[FEN_BIT]))
		else $error("fraction enable mismatch");
	a_edge_rate_follow:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		$changed(ctl_reg[SLEW_BIT]) |-> ch5_edge_rate == ctl_reg[SLEW_BIT])
		else $error("edge rate did not follow");
	a_positive_side:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		s_ctl_write ##1 1'b1 |-> ch5_positive_side_on == ctl_reg[POS_BIT])
		else $error("positive side mismatch");
	a_driver_hcsl:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		ctl_reg[DRV_HI:DRV_LO] == 2'b11 |-> ch5_driver_type == OCFG_DRV_HCSL)
		else $error("driver not hcsl");
	a_static_low:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		ctl_reg[ST_HI:ST_LO] == 2'b10 |-> ch5_static_drive &&
		!ch5_static_level && !ch5_clock_run)
		else $error("static low not forced");
	a_supply_level:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		ch5_supply_level == ctl_reg[SUP_BIT])
		else $error("supply level mismatch");
	a_integer_plus_one:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		ch5_integer_divide == {1'b0, dvh_reg[DIV_HI:DIV_LO]} +
		(INT_W+1)'(1))
		else $error("integer divide not field plus one");
	a_fraction_split:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		s_frac_write |=> ch5_fraction_value[REG_W-1:0] == $past(hw16) &&
		ch5_fraction_value[FRAC_W-1:REG_W] == dvh_reg[FHI_HI:FHI_LO])
		else $error("fraction value split wrong");
	a_ch4_fraction:
	assert property (@(posedge core_clk) disable iff (!reset_n)
		s_c4_write |=> ch4_fraction_value == $past(hw16))
		else $error("channel four fraction not stored");
endmodule
`default_nettype wire

//--- logic/ocfg_pkg.sv
// constants and types for the channel five output configuration block
`default_nettype none
package ocfg_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CH4_FRAC_LO = 6'h0b;
	localparam logic [5:0] IDX_CH5_CTRL = 6'h0c;
	localparam logic [5:0] IDX_CH5_DIV_HI = 6'h0d;
	localparam logic [5:0] IDX_CH5_FRAC_LO = 6'h0e;
	// bus decode
	localparam int ADDR_W = 32;
	localparam int IDX_LO = 2;
	localparam int IDX_HI = 7;
	localparam int REG_W = 16;
	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
	// writable bits; reserved positions always read zero
	localparam logic [15:0] MASK_CH4_FRAC_LO = 16'hffff;
	localparam logic [15:0] MASK_CH5_CTRL = 16'h7fdf;
	localparam logic [15:0] MASK_CH5_DIV_HI = 16'h0fff;
	localparam logic [15:0] MASK_CH5_FRAC_LO = 16'hffff;
	// reset values
	localparam logic [15:0] RST_CH4_FRAC_LO = 16'h0000;
	localparam logic [15:0] RST_CH5_CTRL = 16'h0000;
	localparam logic [15:0] RST_CH5_DIV_HI = 16'h0000;
	localparam logic [15:0] RST_CH5_FRAC_LO = 16'h0000;
	// control register fields
	localparam int SRC_HI = 14;
	localparam int SRC_LO = 13;
	localparam int PRE_HI = 12;
	localparam int PRE_LO = 10;
	localparam int FEN_BIT = 9;
	localparam int SLEW_BIT = 8;
	localparam int NEG_BIT = 7;
	localparam int POS_BIT = 6;
	localparam int DRV_HI = 4;
	localparam int DRV_LO = 3;
	localparam int ST_HI = 2;
	localparam int ST_LO = 1;
	localparam int SUP_BIT = 0;
	// divider register fields
	localparam int DIV_HI = 11;
	localparam int DIV_LO = 4;
	localparam int FHI_HI = 3;
	localparam int FHI_LO = 0;
	localparam int INT_W = 8;
	localparam int FRAC_W = 20;
	// prescale codes and ratios
	localparam logic [2:0] PRE_DIV2 = 3'h0;
	localparam logic [2:0] PRE_DIV3 = 3'h1;
	localparam logic [2:0] PRE_DIV1 = 3'h7;
	localparam logic [1:0] RATIO_NONE = 2'h0;
	localparam logic [1:0] RATIO_1 = 2'h1;
	localparam logic [1:0] RATIO_2 = 2'h2;
	localparam logic [1:0] RATIO_3 = 2'h3;
	typedef enum logic [1:0] {
		OCFG_SRC_PLL = 2'b00,
		OCFG_SRC_PRIMARY = 2'b01,
		OCFG_SRC_SECONDARY = 2'b10
	} ocfg_source_e;
	typedef enum logic [1:0] {
		OCFG_DRV_LVDS = 2'b00,
		OCFG_DRV_LVCMOS = 2'b10,
		OCFG_DRV_HCSL = 2'b11
	} ocfg_driver_e;
	typedef enum logic [1:0] {
		OCFG_ST_OFF = 2'b00,
		OCFG_ST_RUN = 2'b01,
		OCFG_ST_LOW = 2'b10,
		OCFG_ST_HIGH = 2'b11
	} ocfg_state_e;
endpackage
`default_nettype wire

//--- verification/ocfg_testbench.sv
// self-checking bench for the channel five output configuration block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("MISMATCH %s exp %0h got %0h", nm, e, g); \
	end \
end
module testbench;
	import ocfg_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic vco_above_2g4 = 1'b0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	ocfg_source_e ch5_source_select;
	ocfg_driver_e ch5_driver_type;
	ocfg_state_e ch5_output_state;
	logic [2:0] ch5_prescale_code;
	logic [1:0] ch5_prescale_ratio;
	logic ch5_prescale_bypass, ch5_prescale_illegal, ch5_fraction_enable;
	logic ch5_edge_rate, ch5_positive_side_on, ch5_negative_side_on;
	logic ch5_clock_run, ch5_static_drive, ch5_static_level;
	logic ch5_supply_level;
	logic [INT_W:0] ch5_integer_divide;
	logic [FRAC_W-1:0] ch5_fraction_value;
	logic [REG_W-1:0] ch4_fraction_value;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	// model of the four registers, reset to zero
	int m[4] = '{0, 0, 0, 0};
	int msk[4] = '{MASK_CH4_FRAC_LO, MASK_CH5_CTRL, MASK_CH5_DIV_HI,
		MASK_CH5_FRAC_LO};
	logic [31:0] amap[6] = '{32'h2c, 32'h30, 32'h34, 32'h38, 32'h3c, 32'h130};
	// lfsr seeded with 42498
	logic [15:0] lfsr = 16'ha602;

	ocfg_ch5_config ocfg_ch5_config_inst (.core_clk(core_clk),
		.reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.vco_above_2g4(vco_above_2g4), .ch5_source_select(ch5_source_select),
		.ch5_prescale_code(ch5_prescale_code),
		.ch5_prescale_ratio(ch5_prescale_ratio),
		.ch5_prescale_bypass(ch5_prescale_bypass),
		.ch5_prescale_illegal(ch5_prescale_illegal),
		.ch5_fraction_enable(ch5_fraction_enable),
		.ch5_edge_rate(ch5_edge_rate),
		.ch5_positive_side_on(ch5_positive_side_on),
		.ch5_negative_side_on(ch5_negative_side_on),
		.ch5_driver_type(ch5_driver_type),
		.ch5_output_state(ch5_output_state), .ch5_clock_run(ch5_clock_run),
		.ch5_static_drive(ch5_static_drive),
		.ch5_static_level(ch5_static_level),
		.ch5_supply_level(ch5_supply_level),
		.ch5_integer_divide(ch5_integer_divide),
		.ch5_fraction_value(ch5_fraction_value),
		.ch4_fraction_value(ch4_fraction_value));

	always #4 core_clk = ~core_clk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int slot(input logic [31:0] a);
		if (a[31:8] != 24'h0 || a[7:2] < IDX_CH4_FRAC_LO ||
			a[7:2] > IDX_CH5_FRAC_LO) begin
			return -1;
		end
		return int'(a[7:2] - IDX_CH4_FRAC_LO);
	endfunction

	task automatic finish_test();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one single transfer; waits on hready at both phases
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, input logic [2:0] sz, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ_BIT;
		haddr <= a;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic check_all();
		int c, d, s, p, r, v, t;
		c = m[1];
		d = m[2];
		s = (c >> 13) & 3;
		p = (c >> 10) & 7;
		r = (p == 0) ? 2 : (p == 1) ? 3 : (p == 7) ? 1 : 0;
		// a bypassed prescaler counts as divide by one
		if (((c >> 9) & 1) == 0) begin
			r = 1;
		end
		v = (c >> 3) & 3;
		t = (c >> 1) & 3;
		`CHK("source", (s == 3) ? 0 : s, ch5_source_select)
		`CHK("pre_code", p, ch5_prescale_code)
		`CHK("ratio", r, ch5_prescale_ratio)
		`CHK("bypass", ((c >> 9) & 1) ^ 1, ch5_prescale_bypass)
		`CHK("frac_en", (c >> 9) & 1, ch5_fraction_enable)
		`CHK("edge", (c >> 8) & 1, ch5_edge_rate)
		`CHK("pos", (c >> 6) & 1, ch5_positive_side_on)
		`CHK("neg", (c >> 7) & (c >> 6) & 1, ch5_negative_side_on)
		`CHK("driver", (v == 1) ? 0 : v, ch5_driver_type)
		`CHK("state", t, ch5_output_state)
		`CHK("run", t == 1, ch5_clock_run)
		`CHK("static", t >> 1, ch5_static_drive)
		`CHK("level", t == 3, ch5_static_level)
		`CHK("supply", c & 1, ch5_supply_level)
		`CHK("int_div", ((d >> 4) & 255) + 1, ch5_integer_divide)
		`CHK("fraction", ((d & 15) << 16) | m[3], ch5_fraction_value)
		`CHK("ch4_frac", m[0], ch4_fraction_value)
		// only judged with the divider on, where both readings agree
		if (((c >> 9) & 1) == 1) begin
			`CHK("illegal", r == 0 || (p == 7 && vco_above_2g4),
				ch5_prescale_illegal)
		end
	endtask

	task automatic wr(input logic [31:0] a, input int d, input logic [2:0] sz);
		logic [31:0] q;
		int k;
		k = slot(a);
		bus(1'b1, a, d, sz, q);
		// reserved bits are dropped, so the model masks them too
		if (k >= 0 && sz == 3'h2) begin
			m[k] = d & msk[k];
		end
		#1;
		check_all();
	endtask

	task automatic rd(input logic [31:0] a);
		logic [31:0] q;
		int k;
		k = slot(a);
		bus(1'b0, a, 32'h0, 3'h2, q);
		`CHK("rdata", (k >= 0) ? m[k] : 0, q)
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		int i;
		int j;
		int v;
		logic [7:0] k;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		#1;
		check_all();
		for (i = 0; i < 4; i++) begin
			rd(amap[i]);
		end
		// sweep every source, prescale, driver and state code
		for (i = 0; i < 256; i++) begin
			k = i[7:0];
			@(posedge core_clk);
			vco_above_2g4 <= k[0];
			v = {16'h0, 1'b0, k[1:0], k[4:2], k[5], k[6], k[7], k[3], 1'b0,
				k[7:6], k[2:1], k[4]};
			wr(32'h30, v, 3'h2);
			rd(32'h30);
		end
		// random data to all registers, unmapped places and odd sizes
		for (i = 0; i < 80; i++) begin
			lfsr = lfsr_next(lfsr);
			k = lfsr[7:0];
			lfsr = lfsr_next(lfsr);
			j = k % 6;
			// software keeps reserved bits of mapped registers at zero
			v = (j < 4) ? (int'(lfsr) & msk[j]) : int'(lfsr);
			wr(amap[j], v, (k[7:5] == 3'h0) ? 3'h1 : 3'h2);
			rd(amap[(k >> 3) % 6]);
		end
		// reset in mid-run clears the four registers and hrdata; integer divide resets to one
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("rst_div", 1, ch5_integer_divide)
		`CHK("rst_rdata", 0, hrdata)
		@(posedge core_clk);
		reset_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			m[i] = 0;
		end
		@(posedge core_clk);
		#1;
		check_all();
		rd(32'h30);
		finish_test();
	end
endmodule
`default_nettype wire
